/* File: shared/mss_regs.vh */
// Register offsets, field positions and reset values of the modulation source select block
`ifndef MSS_REGS_VH
`define MSS_REGS_VH

`define MSS_ADDR_W             2
`define MSS_OFF_CONTROL        2'h0
`define MSS_OFF_SOURCE         2'h1

`define MSS_CTL_ENABLE_BIT     7
`define MSS_CTL_STATUS_BIT     3
`define MSS_CTL_SWBIT_BIT      0
`define MSS_CTL_RESET          1'h0

`define MSS_SRC_PINDIS_BIT     7
`define MSS_SRC_SEL_HI         3
`define MSS_SRC_SEL_LO         0
`define MSS_SRC_PINDIS_RESET   1'h0
`define MSS_SRC_SEL_RESET      4'h0

`define MSS_SEL_SWBIT          4'h0
`define MSS_SEL_PIN            4'h1
`define MSS_SEL_PWM1           4'h2
`define MSS_SEL_PWM2           4'h3
`define MSS_SEL_PWM3           4'h4
`define MSS_SEL_PWM4           4'h5
`define MSS_SEL_CMP1           4'h6
`define MSS_SEL_CMP2           4'h7
`define MSS_SEL_SER1           4'h8
`define MSS_SEL_SER2           4'h9
`define MSS_SEL_UART           4'ha
`define MSS_NUM_SOURCES        11

`endif

/* File: logic/mss_modulation_source_select.v */
// Modulation source selector with its control and source registers
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "mss_regs.vh"

// Summary of operation
// (R1) Pin disable bit releases selected source's pin
// (R2) Four-bit low field picks modulation source
// (R3) Reserved high codes connect no source
// (R4) Codes 0111/0110 take comparator two/one
// (R5) Codes 0101..0010 take PWM units, PWM-only
// (R6) Software bit counts only when selected
// (R7) Status bit is output sampled by clock
// (R8) Control bit 0 is software modulation bit
// (R9) Reset disables modulator, registers to defaults
// (R10) Unused source bits read zero, ignore writes
module mss_modulation_source_select (
    input  wire                   sys_clk,
    input  wire                   reset,
    input  wire [`MSS_ADDR_W-1:0] reg_addr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_write,
    input  wire                   reg_read,
    output reg  [7:0]             reg_rdata,
    input  wire                   modulation_pin_in,
    input  wire [1:0]             comparator_out,
    input  wire [3:0]             pwm_unit_out,
    input  wire [3:0]             pwm_unit_pwm_mode,
    input  wire [1:0]             serial_data_out,
    input  wire                   uart_tx_out,
    output reg                    modulation_signal,
    output reg  [`MSS_NUM_SOURCES-1:0] source_pin_release
);

    reg        module_enable;
    reg        software_modulation_bit;
    reg        source_pin_disable;
    reg  [3:0] source_select;
    reg        output_status_bit;
    reg        pin_meta;
    reg        pin_sync;
    reg        selected_level;
    wire [15:0] source_vec;
    wire [`MSS_NUM_SOURCES-1:0] next_source_pin_release;

    // Only the off-chip modulation pin needs synchronising
    always @(posedge sys_clk) begin
        if (reset) begin
            pin_meta <= 1'h0;
            pin_sync <= 1'h0;
        end else begin
            pin_meta <= modulation_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // PWM sources pass only while their unit is in PWM output mode
    assign source_vec = {5'h00,                                              // see (R3)
                         uart_tx_out,
                         serial_data_out[1],
                         serial_data_out[0],
                         comparator_out[1],                                  // see (R4)
                         comparator_out[0],                                  // see (R4)
                         pwm_unit_out & pwm_unit_pwm_mode,                   // see (R5)
                         pin_sync,
                         software_modulation_bit};                           // see (R6)

    always @* begin
        selected_level = source_vec[source_select];                          // see (R2)
    end

    genvar i;
    generate
        for (i = 0; i < `MSS_NUM_SOURCES; i = i + 1) begin : g_release
            localparam [3:0] CODE = i;
            assign next_source_pin_release[i] = source_pin_disable &&
                                                (source_select == CODE);     // see (R1)
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (reset) begin
            module_enable           <= `MSS_CTL_RESET;                       // see (R9)
            software_modulation_bit <= `MSS_CTL_RESET;
            source_pin_disable      <= `MSS_SRC_PINDIS_RESET;
            source_select           <= `MSS_SRC_SEL_RESET;
        end else if (reg_write) begin
            if (reg_addr == `MSS_OFF_CONTROL) begin
                module_enable           <= reg_wdata[`MSS_CTL_ENABLE_BIT];
                software_modulation_bit <= reg_wdata[`MSS_CTL_SWBIT_BIT];    // see (R8)
            end
            if (reg_addr == `MSS_OFF_SOURCE) begin
                source_pin_disable <= reg_wdata[`MSS_SRC_PINDIS_BIT];
                source_select <= reg_wdata[`MSS_SRC_SEL_HI:`MSS_SRC_SEL_LO]; // see (R10)
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            modulation_signal  <= 1'h0;
            source_pin_release <= {`MSS_NUM_SOURCES{1'h0}};
            output_status_bit  <= 1'h0;
            reg_rdata          <= 8'h00;
        end else begin
            modulation_signal  <= module_enable & selected_level;
            source_pin_release <= next_source_pin_release;
            // Sampled copy; misses pulses shorter than a clock period
            output_status_bit  <= modulation_signal;                         // see (R7)
            reg_rdata          <= 8'h00;
            if (reg_read) begin
                case (reg_addr)
                    `MSS_OFF_CONTROL: begin
                        reg_rdata <= {module_enable, 3'h0, output_status_bit,
                                      2'h0, software_modulation_bit};
                    end
                    `MSS_OFF_SOURCE: begin
                        reg_rdata <= {source_pin_disable, 3'h0, source_select}; // see (R10)
                    end
                    default: begin
                        reg_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/mss_monitor.sv */
// Assertion checker for the modulation source selector
`timescale 1ns/1ns
`default_nettype none
module mss_monitor (
    input wire logic        sys_clk, reset, reg_write, reg_read, modulation_signal,
    input wire logic [1:0]  reg_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    input wire logic [10:0] source_pin_release
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence src_wr; reg_write && reg_addr == 2'h1; endsequence
    src_pad_a: assert property (reg_read && reg_addr == 2'h1 |=> reg_rdata[6:4] == 3'h0)
        else $error("source pad");
    ctl_pad_a: assert property (reg_read && reg_addr == 2'h0 |=> reg_rdata[2:1] == 2'h0)
        else $error("control pad");
    unmapped_a: assert property (reg_read && reg_addr[1] |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    one_release_a: assert property ($onehot0(source_pin_release)) else $error("release");
    pin_keep_a: assert property (src_wr ##0 !reg_wdata[7] |=> ##1 !source_pin_release)
        else $error("pin kept");
    pin_free_a: assert property (src_wr ##0 reg_wdata == 8'h86 |=> ##1 source_pin_release[6])
        else $error("pin freed");
    reserved_a: assert property (src_wr ##0 reg_wdata[3:0] > 4'ha |=> ##1 !source_pin_release)
        else $error("reserved");
    reset_off_a: assert property (disable iff (1'b0) reset |=> !modulation_signal)
        else $error("reset");
endmodule
bind mss_modulation_source_select mss_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
    .reg_write(reg_write), .reg_read(reg_read), .modulation_signal(modulation_signal),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .source_pin_release(source_pin_release));
`default_nettype wire

/* File: tb/mss_src.sv */
// Model of the on-chip signal sources and the off-chip modulation pin feeding the selector
`timescale 1ns/1ns
`default_nettype none
module mss_src (
    input wire logic [10:0] pat,
    input wire logic        on,
    output logic            pin,
    output logic [1:0]      cmp,
    output logic [3:0]      pwm,
    output logic [3:0]      mode,
    output logic [1:0]      ser,
    output logic            tx
);
    // Bit k of pat is the level of the source behind code k, for codes 1 to 10; bit 0 is unused
    assign {tx, ser, cmp, pwm, pin} = pat[10:1];
    assign mode = {4{on}};
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the modulation source selector
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, on = 1, ms, pin, tx;
    logic [1:0]  reg_addr = 0, cmp, ser;
    logic [3:0]  pwm, mode;
    logic [7:0]  reg_wdata = 0, reg_rdata;
    logic [10:0] pat = 0, rel;
    int          fail_count = 0, checks_done = 0, k, v, e;
    mss_src src (.pat(pat), .on(on), .pin(pin), .cmp(cmp), .pwm(pwm), .mode(mode), .ser(ser),
        .tx(tx));
    mss_modulation_source_select dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .modulation_pin_in(pin), .comparator_out(cmp), .pwm_unit_out(pwm),
        .pwm_unit_pwm_mode(mode), .serial_data_out(ser), .uart_tx_out(tx),
        .modulation_signal(ms), .source_pin_release(rel));
    task chk(input logic [10:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk) reg_write <= 0;
    endtask
    task rd(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_read, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_read <= 0;
        #1 chk(reg_rdata, d);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 0;
        rd(1, 8'h00);
        wr(2, 8'hff);
        rd(2, 8'h00);
        wr(1, 8'h7f);
        rd(1, 8'h0f);
        for (k = 0; k < 16; k++) for (v = 0; v < 2; v++) begin
            e = v && k < 11;
            pat <= v ? 11'h1 << k : ~(11'h1 << k);
            wr(0, 8'h80 | v);
            wr(1, 8'h80 | k);
            repeat (5) @(posedge sys_clk);
            chk(ms, e);
            chk(rel, 11'h1 << k);
            rd(0, 8'h80 | e << 3 | v);
        end
        on <= 0;
        pat <= 11'h7ff;
        wr(1, 8'h03);
        repeat (5) @(posedge sys_clk);
        chk(ms, 0);
        wr(1, 8'h86);
        reset <= 1;
        repeat (2) @(posedge sys_clk);
        reset <= 0;
        chk(rel, 0);
        rd(1, 8'h00);
        rd(0, 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
